// File: design/tcp_pkg.sv
`default_nettype none

package tcp_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] ADDR_ADJUST = 8'h61;  // Thermal charge adjust.
  localparam logic [7:0] ADDR_COLD   = 8'h62;  // Cold threshold.
  localparam logic [7:0] ADDR_COOL   = 8'h63;  // Cool threshold.
  localparam logic [7:0] ADDR_WARM   = 8'h64;  // Warm threshold.
  localparam logic [7:0] ADDR_HOT    = 8'h65;  // Hot threshold.
  localparam logic [7:0] ADDR_PART   = 8'h6F;  // Part identifier.

  // ****************************************************************
  // Reset values and fixed codes.
  // ****************************************************************
  localparam logic [7:0] RST_ADJUST = 8'h34;  // Reduction 3, scale 4.
  localparam logic [7:0] RST_COLD   = 8'h7C;  // Cold threshold reset.
  localparam logic [7:0] RST_COOL   = 8'h6D;  // Cool threshold reset.
  localparam logic [7:0] RST_WARM   = 8'h38;  // Warm threshold reset.
  localparam logic [7:0] RST_HOT    = 8'h27;  // Hot threshold reset.
  localparam logic [7:0] PART_CODE  = 8'hA5;  // Arbitrary value.

  // ****************************************************************
  // Field positions and scaling.
  // ****************************************************************
  localparam int VRED_LSB = 4;  // Warm voltage reduction field, bits 6..4.
  localparam int ISCL_LSB = 0;  // Thermal current scale field, bits 2..0.
  localparam logic [8:0] VRED_STEP_MV = 9'h032;  // 50 mV per code step.

  // Thermal zone; a higher sense voltage means a colder battery.
  typedef enum logic [2:0] {
    TCP_ZONE_COLD   = 3'b000,
    TCP_ZONE_COOL   = 3'b001,
    TCP_ZONE_NORMAL = 3'b010,
    TCP_ZONE_WARM   = 3'b011,
    TCP_ZONE_HOT    = 3'b100
  } tcp_zone_t;

  // Register access request from the serial bus engine.
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle.
    logic       rd;     // Read strobe, one cycle.
    logic [7:0] addr;   // Register address.
    logic [7:0] wdata;  // Write data.
  } tcp_req_t;

  // Charge adjustments handed to the charger loops.
  typedef struct packed {
    tcp_zone_t  zone;         // Present thermal zone.
    logic [8:0] vreg_cut_mv;  // Regulation reduction in millivolts.
    logic [3:0] fast_charge_current_eighths; // Fast charge current in eighths, 8 is full.
    logic       charge_stop;  // Charging suspended in cold or hot.
  } tcp_adj_t;

endpackage

`default_nettype wire

// File: design/tcp_zone_cmp.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Zone classifier: compares the sense code against four thresholds.
// ****************************************************************
module tcp_zone_cmp (
  input  wire logic [7:0]         sense,  // Digitised thermistor voltage.
  input  wire logic [7:0]         cold,   // Cold threshold.
  input  wire logic [7:0]         cool,   // Cool threshold.
  input  wire logic [7:0]         warm,   // Warm threshold.
  input  wire logic [7:0]         hot,    // Hot threshold.
  output var  tcp_pkg::tcp_zone_t zone    // Classified zone.
);

  // The extremes are tested first so that misordered thresholds fail safe.
  always_comb
  begin
    if (sense >= cold)
      zone = tcp_pkg::TCP_ZONE_COLD;
    else if (sense <= hot)
      zone = tcp_pkg::TCP_ZONE_HOT;
    else if (sense >= cool)
      zone = tcp_pkg::TCP_ZONE_COOL;
    else if (sense <= warm)
      zone = tcp_pkg::TCP_ZONE_WARM;
    else
      zone = tcp_pkg::TCP_ZONE_NORMAL;
  end

endmodule
`default_nettype wire

// File: design/tcp_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tcp_regs (
  input  wire logic              clock,      // 250 MHz core clock.
  input  wire logic              rstn,       // Asynchronous reset, active low.
  input  wire tcp_pkg::tcp_req_t req,        // Register request, same clock.
  input  wire logic [7:0]        sense,      // Thermistor code, same clock.
  output var  logic [7:0]        rdata,      // Read data, registered.
  output var  logic              rvalid,     // Read data valid, one cycle.
  output var  tcp_pkg::tcp_adj_t adj         // Charge adjustments, registered.
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [7:0] thermal_charge_adjust;  // Adjust register, all bits writable.
  logic [7:0] cold_threshold;         // Cold threshold code.
  logic [7:0] cool_threshold;         // Cool threshold code.
  logic [7:0] warm_threshold;         // Warm threshold code.
  logic [7:0] hot_threshold;          // Hot threshold code.

  // ****************************************************************
  // Decode.
  // ****************************************************************
  wire logic hit_adjust = req.addr == tcp_pkg::ADDR_ADJUST;  // Adjust selected.
  wire logic hit_cold   = req.addr == tcp_pkg::ADDR_COLD;    // Cold selected.
  wire logic hit_cool   = req.addr == tcp_pkg::ADDR_COOL;    // Cool selected.
  wire logic hit_warm   = req.addr == tcp_pkg::ADDR_WARM;    // Warm selected.
  wire logic hit_hot    = req.addr == tcp_pkg::ADDR_HOT;     // Hot selected.
  wire logic hit_part   = req.addr == tcp_pkg::ADDR_PART;    // Identifier.

  wire logic [2:0] warm_voltage_reduction =
    thermal_charge_adjust[tcp_pkg::VRED_LSB +: 3];  // Warm cut code.
  wire logic [2:0] thermal_current_scale =
    thermal_charge_adjust[tcp_pkg::ISCL_LSB +: 3];  // Current scale code.

  // Unmapped addresses read as zero; the identifier is a constant.
  wire logic [7:0] next_rdata =
    hit_adjust ? thermal_charge_adjust :
    hit_cold   ? cold_threshold :
    hit_cool   ? cool_threshold :
    hit_warm   ? warm_threshold :
    hit_hot    ? hot_threshold :
    hit_part   ? tcp_pkg::PART_CODE :
    8'h00;

  tcp_pkg::tcp_zone_t zone_now;  // Combinational zone.

  tcp_zone_cmp u_cmp (
    .sense (sense),
    .cold  (cold_threshold),
    .cool  (cool_threshold),
    .warm  (warm_threshold),
    .hot   (hot_threshold),
    .zone  (zone_now)
  );

  // Cut applies only in warm: code times 50 mV.
  wire logic [8:0] next_cut =
    (zone_now == tcp_pkg::TCP_ZONE_WARM) ?
    9'(warm_voltage_reduction * tcp_pkg::VRED_STEP_MV) : 9'h000;

  // Current is reduced in cool and warm; code n leaves 8 - n eighths.
  wire logic thermal_reduce =
    (zone_now == tcp_pkg::TCP_ZONE_COOL) || (zone_now == tcp_pkg::TCP_ZONE_WARM);
  wire logic [3:0] next_eighths =
    thermal_reduce ? (4'h8 - {1'b0, thermal_current_scale}) : 4'h8;

  wire logic next_stop =
    (zone_now == tcp_pkg::TCP_ZONE_COLD) || (zone_now == tcp_pkg::TCP_ZONE_HOT);

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Writes to the identifier or unmapped addresses are dropped.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      // Power-on codes; both adjust fields come out of the one byte.
      thermal_charge_adjust <= tcp_pkg::RST_ADJUST;
      cold_threshold        <= tcp_pkg::RST_COLD;
      cool_threshold        <= tcp_pkg::RST_COOL;
      warm_threshold        <= tcp_pkg::RST_WARM;
      hot_threshold         <= tcp_pkg::RST_HOT;
    end
    else if (req.wr)
    begin
      // Reserved bits 7 and 3 are stored like the rest.
      if (hit_adjust) thermal_charge_adjust <= req.wdata;
      if (hit_cold)   cold_threshold        <= req.wdata;
      if (hit_cool)   cool_threshold        <= req.wdata;
      if (hit_warm)   warm_threshold        <= req.wdata;
      if (hit_hot)    hot_threshold         <= req.wdata;
    end
  end

  // ****************************************************************
  // Read port.
  // ****************************************************************
  // Read data arrives one cycle after the strobe and then holds.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      // The valid pulse follows the strobe; data only moves on a read.
      rvalid <= req.rd;
      if (req.rd)
        rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Charge adjustment outputs.
  // ****************************************************************
  // Registered so the charger loops see a clean value; one cycle late.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      adj.zone         <= tcp_pkg::TCP_ZONE_NORMAL;
      adj.vreg_cut_mv  <= 9'h000;
      adj.fast_charge_current_eighths <= 4'h8;
      adj.charge_stop  <= 1'b0;
    end
    else
    begin
      // Updated every edge, so a threshold write shows one cycle later.
      adj.zone         <= zone_now;
      adj.vreg_cut_mv  <= next_cut;
      adj.fast_charge_current_eighths <= next_eighths;
      adj.charge_stop  <= next_stop;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // All checks share the core clock and stand down while reset is low.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Field reset codes, seen at the first edge after reset lifts.
  chk_vred_reset: assert property ($rose(rstn) |-> warm_voltage_reduction == 3'h3)
    else $error("warm reduction not 011 after reset");
  chk_iscl_reset: assert property ($rose(rstn) |-> thermal_current_scale == 3'h4)
    else $error("current scale not 100 after reset");

  // Writes land at the strobe edge and read back on the following one.
  chk_adjust_write: assert property (req.wr && hit_adjust ##1 req.rd && hit_adjust |=>
    rdata == $past(req.wdata, 2))
    else $error("adjust register readback wrong");
  chk_cold_write: assert property (req.wr && hit_cold |=>
    cold_threshold == $past(req.wdata))
    else $error("cold threshold not written");
  chk_cool_write: assert property (req.wr && hit_cool |=>
    cool_threshold == $past(req.wdata))
    else $error("cool threshold not written");
  chk_warm_write: assert property (req.wr && hit_warm |=>
    warm_threshold == $past(req.wdata))
    else $error("warm threshold not written");
  chk_hot_write: assert property (req.wr && hit_hot |=>
    hot_threshold == $past(req.wdata))
    else $error("hot threshold not written");
  chk_part_read: assert property (req.rd && hit_part |=>
    rvalid && rdata == tcp_pkg::PART_CODE)
    else $error("part identifier read wrong");

  // One valid pulse per read strobe, and read data that waits for the host.
  chk_rvalid_pulse: assert property (rvalid == $past(req.rd))
    else $error("read valid does not follow the strobe");
  chk_rdata_hold: assert property (!$past(req.rd) |-> $stable(rdata))
    else $error("read data changed without a read");

  // Adjustments follow the zone one edge late.
  chk_warm_cut: assert property (adj.zone == tcp_pkg::TCP_ZONE_WARM |->
    adj.vreg_cut_mv == 9'($past(warm_voltage_reduction) * 50))
    else $error("warm cut value wrong");
  chk_no_cut: assert property (adj.zone != tcp_pkg::TCP_ZONE_WARM |->
    adj.vreg_cut_mv == 9'h000)
    else $error("cut outside warm zone");
  chk_cur_scale: assert property ((adj.zone == tcp_pkg::TCP_ZONE_COOL ||
    adj.zone == tcp_pkg::TCP_ZONE_WARM) |->
    adj.fast_charge_current_eighths + 4'($past(thermal_current_scale)) == 4'h8)
    else $error("current scale wrong");
  // Outside cool and warm the full programmed current must apply.
  chk_full_current: assert property (adj.zone != tcp_pkg::TCP_ZONE_COOL &&
    adj.zone != tcp_pkg::TCP_ZONE_WARM |-> adj.fast_charge_current_eighths == 4'h8)
    else $error("current reduced outside cool and warm");

  // Both extremes stop the charge whatever the inner thresholds hold.
  chk_zone_hot: assert property (sense <= hot_threshold && sense < cold_threshold |=>
    adj.zone == tcp_pkg::TCP_ZONE_HOT && adj.charge_stop)
    else $error("hot zone not detected");
  chk_zone_cold: assert property (sense >= cold_threshold |=>
    adj.zone == tcp_pkg::TCP_ZONE_COLD && adj.charge_stop)
    else $error("cold zone not detected");

  // Main scenarios worth seeing at least once.
  cov_warm: cover property (adj.zone == tcp_pkg::TCP_ZONE_WARM);
  cov_cold: cover property (adj.zone == tcp_pkg::TCP_ZONE_COLD);
  cov_part: cover property (req.rd && hit_part);
  cov_write_then_read: cover property (req.wr && hit_hot ##1 req.rd && hit_hot);
  cov_read_and_write: cover property (req.wr && req.rd);

endmodule
`default_nettype wire

// File: tb/tcp_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host model: issues single-cycle register requests.
// ****************************************************************
module tcp_host (
  input  wire logic              clock,  // Core clock.
  output var  tcp_pkg::tcp_req_t req,    // Request to the bank.
  input  wire logic [7:0]        rdata,  // Read data.
  input  wire logic              rvalid  // Read data valid.
);
  // The bus starts idle.
  initial req = '0;

  // One strobe for one cycle; when idle the lines show the inverse of the last value.
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= {w, !w, a, d};
    @(negedge clock);
    req <= {1'b0, 1'b0, ~a, ~d};
  endtask

  // The valid pulse stands one cycle only, so the answer is taken right after the strobe edge.
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
    put(1'b0, a, 8'h00);
    v = rvalid;
    d = rdata;
  endtask

  // Write, then read the same address on the next edge, or on the same edge when same is set.
  // The answer is taken at the falling edge after the read edge, while rvalid stands.
  task automatic pair(input logic same, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(negedge clock);
    req <= {1'b1, same, a, d};
    if (!same)
    begin
      @(negedge clock);
      req <= {1'b0, 1'b1, a, ~d};
    end
    @(negedge clock);
    req <= {1'b0, 1'b0, ~a, ~d};
    v = rvalid;
    q = rdata;
  endtask
endmodule

`default_nettype wire

// File: tb/thermal_charge_profile_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench for the thermal charge profile register bank.
// ****************************************************************
module thermal_charge_profile_regs_tb;
  logic              clock;          // Core clock, 4 ns.
  logic              rstn;           // Reset, active low.
  logic [7:0]        sense;          // Thermistor code.
  tcp_pkg::tcp_req_t req;            // Request from the host.
  logic [7:0]        rdata;          // Read data.
  logic              rvalid;         // Read valid.
  tcp_pkg::tcp_adj_t adj;            // Charge adjustments.
  int                n_fail = 0;     // Mismatches.
  int                cmp_count = 0;  // Comparisons.
  int                cycles = 0;     // Cycle count for the hang guard.

  tcp_regs dut (.clock(clock), .rstn(rstn), .req(req), .sense(sense), .rdata(rdata),
                .rvalid(rvalid), .adj(adj));
  tcp_host host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));

  // Free-running clock.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.get(a, d, v);
    chk("rvalid", {15'h0, v}, 16'h0001);
    chk("rdata", {8'h00, d}, {8'h00, exp});
  endtask

  // Sense changes at the falling edge; adjustments show one edge later.
  task automatic adjchk(input logic [7:0] s, input logic [2:0] z, input int cut,
                        input int eig, input logic stop);
    @(negedge clock);
    sense = s;
    @(negedge clock);
    chk("zone", {13'h0, adj.zone}, {13'h0, z});
    chk("cut", {7'h0, adj.vreg_cut_mv}, 16'(cut));
    chk("eighths", {12'h0, adj.fast_charge_current_eighths}, 16'(eig));
    chk("stop", {15'h0, adj.charge_stop}, {15'h0, stop});
  endtask

  // Reset values, the identifier and an unmapped address.
  task automatic test_reset;
    adjchk(8'h50, 3'd2, 0, 8, 1'b0);
    rdchk(8'h61, 8'h34);
    rdchk(8'h62, 8'h7C);
    rdchk(8'h63, 8'h6D);
    rdchk(8'h64, 8'h38);
    rdchk(8'h65, 8'h27);
    rdchk(8'h6F, tcp_pkg::PART_CODE);
    rdchk(8'h60, 8'h00);
  endtask

  // All ones and all zeros stick, reserved bits too; the identifier ignores writes.
  task automatic test_rw;
    logic [7:0] rst[5] = '{8'h34, 8'h7C, 8'h6D, 8'h38, 8'h27};
    for (int i = 0; i < 5; i++)
    begin
      host.put(1'b1, 8'(8'h61 + i), 8'hFF);
      rdchk(8'(8'h61 + i), 8'hFF);
      host.put(1'b1, 8'(8'h61 + i), 8'h00);
      rdchk(8'(8'h61 + i), 8'h00);
      host.put(1'b1, 8'(8'h61 + i), rst[i]);
    end
    host.put(1'b1, 8'h6F, 8'h00);
    rdchk(8'h6F, tcp_pkg::PART_CODE);
    host.put(1'b1, 8'h66, 8'hFF);
    rdchk(8'h66, 8'h00);
  endtask

  // Every code of both fields in warm and cool, then the band edges.
  task automatic test_zone;
    for (int c = 0; c < 8; c++)
    begin
      host.put(1'b1, 8'h61, {1'b1, 3'(c), 1'b1, 3'(c)});
      adjchk(8'h30, 3'd3, c * 50, 8 - c, 1'b0);
      adjchk(8'h70, 3'd1, 0, 8 - c, 1'b0);
    end
    adjchk(8'h7C, 3'd0, 0, 8, 1'b1);
    adjchk(8'h27, 3'd4, 0, 8, 1'b1);
    adjchk(8'h38, 3'd3, 350, 1, 1'b0);
    adjchk(8'h6D, 3'd1, 0, 1, 1'b0);
    host.put(1'b1, 8'h65, 8'h38);
    adjchk(8'h38, 3'd4, 0, 8, 1'b1);
  endtask

  // Back-to-back write and read, and a read that meets a write on one edge.
  task automatic test_pair;
    logic [7:0] q;
    logic       v;
    host.pair(1'b0, 8'h61, 8'h5A, q, v);
    chk("pair valid", {15'h0, v}, 16'h0001);
    chk("pair adjust", {8'h00, q}, 16'h005A);
    host.pair(1'b0, 8'h65, 8'h30, q, v);
    chk("pair hot", {8'h00, q}, 16'h0030);
    host.pair(1'b1, 8'h64, 8'h40, q, v);
    chk("same edge valid", {15'h0, v}, 16'h0001);
    chk("same edge old", {8'h00, q}, 16'h0038);
    rdchk(8'h64, 8'h40);
  endtask

  // Reset in mid-run: outputs clear at once, registers return to reset codes.
  task automatic test_reset_again;
    @(negedge clock);
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    chk("reset rvalid", {15'h0, rvalid}, 16'h0000);
    chk("reset rdata", {8'h00, rdata}, 16'h0000);
    chk("reset zone", {13'h0, adj.zone}, 16'h0002);
    chk("reset cut", {7'h0, adj.vreg_cut_mv}, 16'h0000);
    chk("reset eighths", {12'h0, adj.fast_charge_current_eighths}, 16'h0008);
    chk("reset stop", {15'h0, adj.charge_stop}, 16'h0000);
    rstn = 1'b1;
    adjchk(8'h38, 3'd3, 150, 4, 1'b0);
    rdchk(8'h61, 8'h34);
    rdchk(8'h64, 8'h38);
    rdchk(8'h65, 8'h27);
  endtask

  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rstn = 1'b0;
    sense = 8'h50;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    test_reset();
    test_rw();
    test_zone();
    test_pair();
    test_reset_again();
    summarize();
  end
endmodule

`default_nettype wire
